//--- design/mcuidt_core.sv
`timescale 1ns/1ps

module mcuidt_core
   import mcuidt_pkg::*;
(
   input  wire logic                       clock,
   input  wire logic                       nrst,
   input  wire logic [`MCUIDT_IW-1:0]      instr_word,
   input  wire logic [7:0]                 reg_rd_data,
   input  wire logic [7:0]                 port_pins,
   input  wire logic                       presc_to_timer,
   output logic      [`MCUIDT_PCW-1:0]     prog_addr,
   output logic      [`MCUIDT_AW-1:0]      reg_addr,
   output logic                            reg_rd_en,
   output logic                            reg_wr_en,
   output logic      [7:0]                 reg_wr_data,
   output logic                            port_read,
   output logic                            presc_clear,
   output mcuidt_group_t                   instr_group,
   output logic                            dest_file,
   output logic      [2:0]                 bit_sel,
   output logic      [`MCUIDT_K11_MSB:0]   literal,
   output logic      [7:0]                 w_value,
   output mcuidt_phase_t                   phase
);

   // ***************************************************************
   // Decode helpers
   // ***************************************************************
   function automatic mcuidt_group_t grp_of(input logic [`MCUIDT_IW-1:0] iw);
      mcuidt_group_t g;
      g = GRP_LIT;
      case (iw[`MCUIDT_GRP_MSB:`MCUIDT_GRP_LSB])
         `MCUIDT_GRPC_BYTE: begin
            // Control words share the byte space; only the NOP pattern stays a byte op
            if (iw[`MCUIDT_OP_MSB:`MCUIDT_OP_LSB] == `MCUIDT_OP_MOVWF && !iw[`MCUIDT_D_BIT]
                && iw[`MCUIDT_CTL_LO_MSB:0] != `MCUIDT_NOP_LO) begin
               g = GRP_LIT;
            end else begin
               g = GRP_BYTE;
            end
         end
         `MCUIDT_GRPC_BIT: g = GRP_BIT;
         default: g = GRP_LIT;
      endcase
      return g;
   endfunction

   function automatic logic has_file(input logic [`MCUIDT_IW-1:0] iw);
      logic [3:0] op;
      op = iw[`MCUIDT_OP_MSB:`MCUIDT_OP_LSB];
      case (iw[`MCUIDT_GRP_MSB:`MCUIDT_GRP_LSB])
         `MCUIDT_GRPC_BYTE: return iw[`MCUIDT_D_BIT]
                                   || (op != `MCUIDT_OP_MOVWF && op != `MCUIDT_OP_CLR);
         `MCUIDT_GRPC_BIT:  return 1'b1;
         default:           return 1'b0;
      endcase
   endfunction

   function automatic logic [3:0] lit_op(input logic [3:0] lop);
      case (lop)
         `MCUIDT_LOP_IOR:                    return `MCUIDT_OP_IOR;
         `MCUIDT_LOP_AND:                    return `MCUIDT_OP_AND;
         `MCUIDT_LOP_XOR:                    return `MCUIDT_OP_XOR;
         `MCUIDT_LOP_SUB0, `MCUIDT_LOP_SUB1: return `MCUIDT_OP_SUB;
         `MCUIDT_LOP_ADD0, `MCUIDT_LOP_ADD1: return `MCUIDT_OP_ADD;
         default:                            return `MCUIDT_OP_MOV;
      endcase
   endfunction

   function automatic mcuidt_alu_t alu(input logic [3:0] op, input logic [7:0] f,
                                       input logic [7:0] w, input logic c);
      mcuidt_alu_t a;
      logic [8:0]  s;
      logic [4:0]  h;
      a = '0;
      a.c = c;
      s = {1'b0, f} + {1'b0, w};
      h = {1'b0, f[3:0]} + {1'b0, w[3:0]};
      a.upd_z = 1'b1;
      case (op)
         `MCUIDT_OP_MOVWF: begin
            a.res = w;
            a.upd_z = 1'b0;
         end
         `MCUIDT_OP_CLR: a.res = `MCUIDT_BYTE_ZERO;
         `MCUIDT_OP_SUB: begin
            s = {1'b0, f} + {1'b0, ~w} + 9'h001;
            h = {1'b0, f[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
            a.res = s[7:0];
            {a.c, a.dc, a.upd_c, a.upd_dc} = {s[8], h[4], 2'h3};
         end
         `MCUIDT_OP_ADD: begin
            a.res = s[7:0];
            {a.c, a.dc, a.upd_c, a.upd_dc} = {s[8], h[4], 2'h3};
         end
         `MCUIDT_OP_DEC: a.res = f - `MCUIDT_BIT_ONE;
         `MCUIDT_OP_IOR: a.res = f | w;
         `MCUIDT_OP_AND: a.res = f & w;
         `MCUIDT_OP_XOR: a.res = f ^ w;
         `MCUIDT_OP_MOV: a.res = f;
         `MCUIDT_OP_COM: a.res = ~f;
         `MCUIDT_OP_INC: a.res = f + `MCUIDT_BIT_ONE;
         `MCUIDT_OP_RRF: {a.res, a.c, a.upd_c, a.upd_z} = {c, f, 2'h2};
         `MCUIDT_OP_RLF: {a.c, a.res, a.upd_c, a.upd_z} = {f, c, 2'h2};
         `MCUIDT_OP_SWAP: {a.res, a.upd_z} = {f[3:0], f[7:4], 1'b0};
         `MCUIDT_OP_DECSZ: {a.res, a.upd_z} = {f - `MCUIDT_BIT_ONE, 1'b0};
         default: {a.res, a.upd_z} = {f + `MCUIDT_BIT_ONE, 1'b0};
      endcase
      return a;
   endfunction

   // ***************************************************************
   // Sequencer state
   // ***************************************************************
   mcuidt_core_st_t         s_r;
   mcuidt_core_st_t         s_nxt;
   logic [`MCUIDT_IW-1:0]   cur;
   logic [7:0]              opnd;
   logic [7:0]              mask;
   logic [7:0]              k8;
   logic [3:0]              aop;
   logic [`MCUIDT_SPW-1:0]  sp_dn;
   logic                    flg;
   logic                    pop;
   mcuidt_alu_t             a;

   mcuidt_qgen u_qgen (
      .clock (clock),
      .nrst  (nrst),
      .phase (phase)
   );

   always_comb begin
      s_nxt = s_r;
      flg = 1'b0;
      pop = 1'b0;
      // A discarded prefetch executes as an all-zero word, which decodes to NOP
      cur = s_r.ir_valid ? s_r.ir : `MCUIDT_NOP_WORD;
      opnd = s_r.rd_port ? s_r.pins_s2 : reg_rd_data;
      k8 = cur[`MCUIDT_K8_MSB:0];
      mask = `MCUIDT_BIT_ONE << cur[`MCUIDT_B_MSB:`MCUIDT_B_LSB];
      sp_dn = s_r.sp - `MCUIDT_SP_STEP;
      aop = (s_r.group == GRP_LIT) ? lit_op(cur[`MCUIDT_OP_MSB:`MCUIDT_OP_LSB])
                                   : cur[`MCUIDT_OP_MSB:`MCUIDT_OP_LSB];
      a = alu(aop, (s_r.group == GRP_LIT) ? k8 : opnd, s_r.w, s_r.c);
      s_nxt.pins_s1 = port_pins;
      s_nxt.pins_s2 = s_r.pins_s1;
      s_nxt.rd_en = 1'b0;
      s_nxt.wr_en = 1'b0;
      s_nxt.port_rd = 1'b0;
      s_nxt.presc_clr = 1'b0;
      case (phase)
         PH_Q1: begin
            s_nxt.group = grp_of(cur);
            s_nxt.addr = cur[`MCUIDT_F_MSB:0];
            s_nxt.dest_file = cur[`MCUIDT_D_BIT];
            s_nxt.bit_sel = cur[`MCUIDT_B_MSB:`MCUIDT_B_LSB];
            s_nxt.lit = cur[`MCUIDT_K11_MSB:0];
            // Words with don't-care address bits never issue a read
            s_nxt.rmw = has_file(cur);
            s_nxt.rd_en = has_file(cur);
            s_nxt.rd_port = has_file(cur) && cur[`MCUIDT_F_MSB:0] == `MCUIDT_SECOND_PORT_ADDR;
            s_nxt.port_rd = s_nxt.rd_port;
            s_nxt.taken = 1'b0;
            s_nxt.target = s_r.pc + `MCUIDT_PC_STEP;
         end
         PH_Q3: begin
            s_nxt.opnd = opnd;
            case (s_r.group)
               GRP_BYTE: begin
                  if (s_r.rmw) begin
                     s_nxt.wr_data = a.res;
                     s_nxt.wr_en = s_r.dest_file;
                     if (!s_r.dest_file) begin
                        s_nxt.w = a.res;
                     end
                     flg = 1'b1;
                     if ((aop == `MCUIDT_OP_DECSZ || aop == `MCUIDT_OP_INCSZ)
                         && a.res == `MCUIDT_BYTE_ZERO) begin
                        s_nxt.taken = 1'b1;
                     end
                  end else if (cur[`MCUIDT_OP_MSB:`MCUIDT_OP_LSB] == `MCUIDT_OP_CLR) begin
                     s_nxt.w = `MCUIDT_BYTE_ZERO;
                     s_nxt.z = 1'b1;
                  end
               end
               GRP_BIT: begin
                  case (cur[`MCUIDT_OP_MSB:`MCUIDT_SUB_LSB])
                     `MCUIDT_BOP_BCF: {s_nxt.wr_en, s_nxt.wr_data} = {1'b1, opnd & ~mask};
                     `MCUIDT_BOP_BSF: {s_nxt.wr_en, s_nxt.wr_data} = {1'b1, opnd | mask};
                     `MCUIDT_BOP_BTFSC: s_nxt.taken = (opnd & mask) == `MCUIDT_BYTE_ZERO;
                     default: s_nxt.taken = (opnd & mask) != `MCUIDT_BYTE_ZERO;
                  endcase
               end
               default: begin
                  if (cur[`MCUIDT_GRP_MSB:`MCUIDT_GRP_LSB] == `MCUIDT_GRPC_JUMP) begin
                     s_nxt.taken = 1'b1;
                     s_nxt.target = {s_r.pc[`MCUIDT_PCW-1:`MCUIDT_PCHI_LSB],
                                     cur[`MCUIDT_K11_MSB:0]};
                     if (cur[`MCUIDT_OP_MSB] == 1'b0) begin
                        // Eight levels; a ninth push silently overwrites the oldest
                        s_nxt.stack[s_r.sp] = s_r.pc;
                        s_nxt.sp = s_r.sp + `MCUIDT_SP_STEP;
                     end
                  end else if (cur[`MCUIDT_GRP_MSB:`MCUIDT_GRP_LSB] == `MCUIDT_GRPC_BYTE) begin
                     pop = k8 == `MCUIDT_CTL_RETURN || k8 == `MCUIDT_CTL_RETFIE;
                  end else begin
                     case (cur[`MCUIDT_OP_MSB:`MCUIDT_SUB_LSB])
                        `MCUIDT_LCLS_MOV: s_nxt.w = k8;
                        `MCUIDT_LCLS_RET: {s_nxt.w, pop} = {k8, 1'b1};
                        default: {s_nxt.w, flg} = {a.res, 1'b1};
                     endcase
                  end
               end
            endcase
            if (pop) begin
               s_nxt.taken = 1'b1;
               s_nxt.sp = sp_dn;
               s_nxt.target = s_r.stack[sp_dn];
            end
            if (flg && a.upd_z) begin
               s_nxt.z = a.res == `MCUIDT_BYTE_ZERO;
            end
            if (flg && a.upd_c) begin
               s_nxt.c = a.c;
            end
            if (flg && a.upd_dc) begin
               s_nxt.dc = a.dc;
            end
            s_nxt.presc_clr = s_nxt.wr_en && s_r.addr == `MCUIDT_FIRST_TIMER_ADDR
                              && presc_to_timer;
         end
         PH_Q4: begin
            // Prefetched word is latched here and dropped if this cycle redirects
            s_nxt.ir = instr_word;
            s_nxt.ir_valid = !s_r.taken;
            s_nxt.pc = s_r.taken ? s_r.target : s_r.pc + `MCUIDT_PC_STEP;
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prog_addr   = s_r.pc;
   assign reg_addr    = s_r.addr;
   assign reg_rd_en   = s_r.rd_en;
   assign reg_wr_en   = s_r.wr_en;
   assign reg_wr_data = s_r.wr_data;
   assign port_read   = s_r.port_rd;
   assign presc_clear = s_r.presc_clr;
   assign instr_group = s_r.group;
   assign dest_file   = s_r.dest_file;
   assign bit_sel     = s_r.bit_sel;
   assign literal     = s_r.lit;
   assign w_value     = s_r.w;

   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   sequence s_cycle_start;
      phase == PH_Q1;
   endsequence
   sequence s_redirect;
      phase == PH_Q4 && s_r.taken;
   endsequence
   sequence s_dead_cycle;
      (!reg_rd_en && !reg_wr_en)[*4];
   endsequence

   a_quarter_cycle: assert property (s_cycle_start |=> (phase != PH_Q1)[*3] ##1 s_cycle_start)
      else $error("instruction cycle is not four clocks");
   a_redirect_nop: assert property (s_redirect |=> s_dead_cycle)
      else $error("cycle after redirect did not run as no-op");
   a_fetch_jump: assert property (s_redirect |=> prog_addr == $past(s_r.target) && !s_r.ir_valid)
      else $error("redirect did not load target and drop prefetch");
   a_fetch_next: assert property ((phase == PH_Q4 && !s_r.taken)
                                  |=> prog_addr == $past(prog_addr) + `MCUIDT_PC_STEP)
      else $error("program address did not step by one");
   a_read_first: assert property (reg_wr_en |-> $past(reg_rd_en, 2)
                                  && reg_addr == $past(reg_addr, 2))
      else $error("register written without prior read");
   a_dest_select: assert property ((phase == PH_Q4 && instr_group == GRP_BYTE && s_r.rmw)
                                   |-> reg_wr_en == dest_file)
      else $error("byte op destination ignored");
   a_port_clear: assert property (port_read |-> reg_rd_en
                                  && reg_addr == `MCUIDT_SECOND_PORT_ADDR)
      else $error("port read strobe without port read");
   a_pin_value: assert property ((phase == PH_Q4 && s_r.rd_port)
                                 |-> s_r.opnd == $past(s_r.pins_s2))
      else $error("port operand not taken from pins");
   a_bit_only: assert property ((instr_group == GRP_BIT && reg_wr_en)
                                |-> ((reg_wr_data ^ s_r.opnd) & ~(`MCUIDT_BIT_ONE << bit_sel))
                                    == `MCUIDT_BYTE_ZERO)
      else $error("bit op touched other bits");
   a_presc_clear: assert property (presc_clear |-> reg_wr_en && $past(presc_to_timer)
                                   && reg_addr == `MCUIDT_FIRST_TIMER_ADDR)
      else $error("prescaler clear without timer write");
   a_dont_care: assert property ((phase == PH_Q1 && !cur[`MCUIDT_D_BIT]
                                  && cur[`MCUIDT_GRP_MSB:`MCUIDT_OP_LSB] == 6'h01)
                                 |=> !reg_rd_en)
      else $error("accumulator clear issued a register read");
   a_literal_field: assert property (phase == PH_Q1 |=> literal == $past(cur[`MCUIDT_K11_MSB:0]))
      else $error("literal field not captured");

endmodule

//--- design/mcuidt_cfg.svh
`ifndef MCUIDT_CFG_SVH
`define MCUIDT_CFG_SVH

// ***************************************************************
// Widths and sizes
// ***************************************************************
`define MCUIDT_IW          14
`define MCUIDT_PCW         13
`define MCUIDT_AW          7
`define MCUIDT_STK         8
`define MCUIDT_SPW         3
`define MCUIDT_PC_STEP     13'h0001
`define MCUIDT_SP_STEP     3'h1
`define MCUIDT_NOP_WORD    14'h0000
`define MCUIDT_BIT_ONE     8'h01
`define MCUIDT_BYTE_ZERO   8'h00

// ***************************************************************
// Instruction word fields
// ***************************************************************
`define MCUIDT_GRP_MSB     13
`define MCUIDT_GRP_LSB     12
`define MCUIDT_OP_MSB      11
`define MCUIDT_OP_LSB      8
`define MCUIDT_SUB_LSB     10
`define MCUIDT_D_BIT       7
`define MCUIDT_F_MSB       6
`define MCUIDT_B_MSB       9
`define MCUIDT_B_LSB       7
`define MCUIDT_K8_MSB      7
`define MCUIDT_K11_MSB     10
`define MCUIDT_PCHI_LSB    11
`define MCUIDT_CTL_LO_MSB  4
`define MCUIDT_NOP_LO      5'h00
`define MCUIDT_CTL_RETURN  8'h08
`define MCUIDT_CTL_RETFIE  8'h09

// ***************************************************************
// Encodings
// ***************************************************************
`define MCUIDT_GRPC_BYTE   2'h0
`define MCUIDT_GRPC_BIT    2'h1
`define MCUIDT_GRPC_JUMP   2'h2
`define MCUIDT_OP_MOVWF    4'h0
`define MCUIDT_OP_CLR      4'h1
`define MCUIDT_OP_SUB      4'h2
`define MCUIDT_OP_DEC      4'h3
`define MCUIDT_OP_IOR      4'h4
`define MCUIDT_OP_AND      4'h5
`define MCUIDT_OP_XOR      4'h6
`define MCUIDT_OP_ADD      4'h7
`define MCUIDT_OP_MOV      4'h8
`define MCUIDT_OP_COM      4'h9
`define MCUIDT_OP_INC      4'hA
`define MCUIDT_OP_DECSZ    4'hB
`define MCUIDT_OP_RRF      4'hC
`define MCUIDT_OP_RLF      4'hD
`define MCUIDT_OP_SWAP     4'hE
`define MCUIDT_OP_INCSZ    4'hF
`define MCUIDT_LOP_IOR     4'h8
`define MCUIDT_LOP_AND     4'h9
`define MCUIDT_LOP_XOR     4'hA
`define MCUIDT_LOP_SUB0    4'hC
`define MCUIDT_LOP_SUB1    4'hD
`define MCUIDT_LOP_ADD0    4'hE
`define MCUIDT_LOP_ADD1    4'hF
`define MCUIDT_LCLS_MOV    2'h0
`define MCUIDT_LCLS_RET    2'h1
`define MCUIDT_BOP_BCF     2'h0
`define MCUIDT_BOP_BSF     2'h1
`define MCUIDT_BOP_BTFSC   2'h2
`define MCUIDT_BOP_BTFSS   2'h3

// ***************************************************************
// Special register addresses
// ***************************************************************
`define MCUIDT_FIRST_TIMER_ADDR  7'h01
`define MCUIDT_SECOND_PORT_ADDR  7'h06

`endif

//--- design/mcuidt_pkg.sv
`include "mcuidt_cfg.svh"

package mcuidt_pkg;

   typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} mcuidt_phase_t;

   typedef enum logic [1:0] {GRP_BYTE, GRP_BIT, GRP_LIT} mcuidt_group_t;

   typedef struct packed {
      mcuidt_phase_t phase;
   } mcuidt_qgen_st_t;

   typedef struct packed {
      logic [7:0] res;
      logic       c;
      logic       dc;
      logic       upd_z;
      logic       upd_c;
      logic       upd_dc;
   } mcuidt_alu_t;

   typedef struct packed {
      logic [`MCUIDT_PCW-1:0]                  pc;
      logic [`MCUIDT_IW-1:0]                   ir;
      logic                                    ir_valid;
      logic                                    taken;
      logic [`MCUIDT_PCW-1:0]                  target;
      logic [7:0]                              w;
      logic                                    c;
      logic                                    dc;
      logic                                    z;
      logic [`MCUIDT_SPW-1:0]                  sp;
      logic [`MCUIDT_STK-1:0][`MCUIDT_PCW-1:0] stack;
      logic [7:0]                              pins_s1;
      logic [7:0]                              pins_s2;
      logic [7:0]                              opnd;
      logic                                    rmw;
      logic                                    rd_port;
      mcuidt_group_t                           group;
      logic                                    dest_file;
      logic [2:0]                              bit_sel;
      logic [`MCUIDT_K11_MSB:0]                lit;
      logic [`MCUIDT_AW-1:0]                   addr;
      logic                                    rd_en;
      logic                                    wr_en;
      logic [7:0]                              wr_data;
      logic                                    port_rd;
      logic                                    presc_clr;
   } mcuidt_core_st_t;

endpackage

//--- design/mcuidt_qgen.sv
`timescale 1ns/1ps

// ***************************************************************
// Quarter-phase generator: four oscillator clocks per cycle
// ***************************************************************
module mcuidt_qgen
   import mcuidt_pkg::*;
(
   input  wire logic    clock,
   input  wire logic    nrst,
   output mcuidt_phase_t phase
);

   mcuidt_qgen_st_t s_r;
   mcuidt_qgen_st_t s_nxt;

   always_comb begin
      s_nxt = s_r;
      case (s_r.phase)
         PH_Q1: s_nxt.phase = PH_Q2;
         PH_Q2: s_nxt.phase = PH_Q3;
         PH_Q3: s_nxt.phase = PH_Q4;
         default: s_nxt.phase = PH_Q1;
      endcase
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign phase = s_r.phase;

endmodule

//--- bench/mcuidt_mem_model.sv
`timescale 1ns/1ps

// ***************************************************
// Program memory and register file on the far side
// ***************************************************
module mcuidt_mem_model
   import mcuidt_pkg::*;
(
   input  wire logic        clock,
   input  wire logic [12:0] prog_addr,
   input  wire logic [6:0]  reg_addr,
   input  wire logic        reg_rd_en,
   input  wire logic        reg_wr_en,
   input  wire logic [7:0]  reg_wr_data,
   output logic      [13:0] instr_word,
   output logic      [7:0]  reg_rd_data
);
   logic [13:0] mem [0:15];
   logic [7:0]  regs [0:127];
   logic        hold;
   initial begin
      instr_word = 14'h0000;
      reg_rd_data = 8'h5A;
      hold = 1'b0;
   end
   // Words past the small program read as no-op
   always @(negedge clock) begin
      instr_word <= (prog_addr < 13'h0010) ? mem[prog_addr[3:0]] : 14'h0000;
      if (reg_rd_en === 1'b1) begin
         reg_rd_data <= regs[reg_addr];
         hold <= 1'b1;
      end else if (hold) begin
         hold <= 1'b0;
      end else begin
         // Released bus toggles so a stale value is never mistaken for data
         reg_rd_data <= ~reg_rd_data;
      end
   end
   always @(posedge clock) begin
      if (reg_wr_en === 1'b1) begin
         regs[reg_addr] <= reg_wr_data;
      end
   end
endmodule

//--- bench/testbench.sv
`timescale 1ns/1ps
`include "mcuidt_cfg.svh"

module testbench;
   import mcuidt_pkg::*;
   logic          clock, nrst, presc_to_timer, rd_en, wr_en, prt, psc, dst, dst_f;
   logic [10:0]   lit, lit_f;
   logic [13:0]   word;
   logic [12:0]   pa;
   logic [7:0]    rdat, wdat, port_pins, w, k, p;
   logic [6:0]    ra, f;
   logic [2:0]    b, bs, bs_f;
   logic [1:0]    x, grp_f;
   mcuidt_phase_t phase;
   mcuidt_group_t grp;
   integer        seed, bad_count, n_checks, rd_cnt, wr_cnt, prt_cnt, psc_cnt, i, it;

   mcuidt_core dut (.clock(clock), .nrst(nrst), .instr_word(word), .reg_rd_data(rdat),
      .port_pins(port_pins), .presc_to_timer(presc_to_timer), .prog_addr(pa),
      .reg_addr(ra), .reg_rd_en(rd_en), .reg_wr_en(wr_en), .reg_wr_data(wdat),
      .port_read(prt), .presc_clear(psc), .instr_group(grp), .dest_file(dst), .bit_sel(bs),
      .literal(lit), .w_value(w), .phase(phase));
   mcuidt_mem_model pm (.clock(clock), .prog_addr(pa), .reg_addr(ra), .reg_rd_en(rd_en),
      .reg_wr_en(wr_en), .reg_wr_data(wdat), .instr_word(word), .reg_rd_data(rdat));

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   always @(negedge clock) begin
      if (nrst) begin
         rd_cnt += (rd_en === 1'b1);
         wr_cnt += (wr_en === 1'b1);
         prt_cnt += (prt === 1'b1);
         psc_cnt += (psc === 1'b1);
         if (wr_en === 1'b1 && ra === f) begin
            grp_f = grp;
            dst_f = dst;
            bs_f = bs;
            lit_f = lit;
         end
      end
   end

   task chk8(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task chkn(input integer got, input integer exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t count %0d exp %0d", $time, got, exp);
      end
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   function automatic logic [7:0] exp_f(input logic [7:0] kk, input logic [2:0] bb);
      return 8'(kk * 3) | (8'h01 << bb);
   endfunction

   initial begin
      seed = 32'hb6a1;
      bad_count = 0;
      n_checks = 0;
      nrst = 1'b0;
      presc_to_timer = 1'b0;
      port_pins = 8'h00;
      for (it = 0; it < 4; it++) begin
         @(negedge clock);
         nrst = 1'b0;
         k = 8'($random(seed));
         p = 8'($random(seed));
         b = 3'($random(seed));
         x = (it == 0) ? 2'h0 : 2'($random(seed));
         f = (it == 1) ? 7'h7F : {2'h1, 5'($random(seed))};
         presc_to_timer = it[0];
         port_pins = p;
         for (i = 0; i < 16; i++) pm.mem[i] = 14'h0000;
         // Accumulator clear with random don't-care bits must never read a register
         pm.mem[0] = {7'h02, 7'($random(seed))};
         pm.mem[1] = {4'hC, x, k};
         pm.mem[2] = {7'h01, f};
         pm.mem[3] = {7'h0E, f};
         pm.mem[4] = {7'h0F, f};
         pm.mem[5] = {4'h5, b, f};
         pm.mem[6] = {7'h03, `MCUIDT_SECOND_PORT_ADDR};
         pm.mem[7] = {7'h11, `MCUIDT_SECOND_PORT_ADDR};
         pm.mem[8] = {7'h03, `MCUIDT_FIRST_TIMER_ADDR};
         pm.mem[9] = 14'h280B;
         pm.mem[10] = 14'h30FF;
         pm.mem[11] = 14'h280B;
         repeat (6) @(negedge clock);
         nrst = 1'b1;
         rd_cnt = 0;
         wr_cnt = 0;
         prt_cnt = 0;
         psc_cnt = 0;
         {grp_f, dst_f, bs_f, lit_f} = 17'h00000;
         for (i = 0; i < 10 && phase !== PH_Q1; i++) @(negedge clock);
         if (i == 10) begin
            bad_count++;
            end_sim();
         end
         for (i = 0; i < 8; i++) begin
            chk8({6'h00, phase}, 8'(i % 4));
            @(negedge clock);
         end
         for (i = 0; i < 200 && pa !== 13'h000B; i++) @(negedge clock);
         if (i == 200) begin
            bad_count++;
            end_sim();
         end
         repeat (12) @(negedge clock);
         chk8(w, 8'(k * 2));
         chk8(pm.regs[f], exp_f(k, b));
         chk8(pm.regs[`MCUIDT_SECOND_PORT_ADDR], p);
         chkn(rd_cnt, 7);
         chkn(wr_cnt, 6);
         chkn(prt_cnt, 2);
         chkn(psc_cnt, it % 2);
         chk8({6'h00, grp_f}, {6'h00, GRP_BIT});
         chk8({5'h00, bs_f}, {5'h00, b});
         chk8({7'h00, dst_f}, {7'h00, b[0]});
         chkn({21'h000000, lit_f}, {21'h000000, 1'b1, b, f});
      end
      end_sim();
   end
endmodule
